// >>> rtl/ebc_regs.sv
// Purpose: External bus control registers and the per-cycle controls they steer.
// Assumes: Classic Wishbone slave; bus cycle requests are one-cycle pulses.
// Notes: Cycle timing itself lives in the bus sequencer outside this block.
//
// Local design decisions: the register offsets and the Wishbone register port.
module ebc_regs
    import ebc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Standby and mode
    input wire logic hw_standby_i,
    input wire logic [2:0] op_mode_i,
    input wire logic single_chip_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // Bus cycle request from the sequencer
    input wire logic cyc_start_i,
    input wire logic cyc_end_i,
    input wire logic cyc_write_i,
    input wire logic cyc_external_i,
    input wire logic [23:0] cyc_addr_i,
    input wire logic wait_pin_n_i,
    // Controls to the sequencer and pins
    output logic insert_idle_o,
    output logic addr_update_o,
    output logic [23:0] addr_o,
    output logic wait_request_o,
    output logic wait_pin_is_port_o,
    output logic [7:0] area_select_n_o,
    output logic [7:4] upper_select_oe_o,
    output logic [2:0] area_o
);
    import ebc_pkg::*;

    logic [7:0] bus_control_r, bus_control_nxt;
    logic [7:0] chip_select_control_r, chip_select_control_nxt;
    logic [7:0] address_method_control_r, address_method_control_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic ack_r, ack_nxt;
    logic err_r, err_nxt;
    // Bus control latched at cycle start so a write never changes a running cycle's wait request.
    logic [7:0] bc_act_r, bc_act_nxt;
    ebc_state_t state_r, state_nxt;
    logic last_read_r, last_read_nxt;
    logic [2:0] last_area_r, last_area_nxt;
    logic [2:0] cur_area_r, cur_area_nxt;
    logic [23:0] addr_r, addr_nxt;
    logic idle_r, idle_nxt;
    logic upd_r, upd_nxt;
    logic [2:0] dec_area;
    logic dec_ext;
    logic even_map;
    logic req;
    logic hit;

    function automatic logic ofs_is(input logic [3:0] a, input logic [3:0] o);
        return a == o;
    endfunction

    assign req = cyc_i && stb_i && !ack_r && !err_r;
    assign hit = ofs_is(adr_i, EBC_OFS_BUS_CONTROL) || ofs_is(adr_i, EBC_OFS_CHIP_SELECT_CONTROL)
        || ofs_is(adr_i, EBC_OFS_ADDRESS_METHOD_CONTROL);

    // Division select is ignored outside modes 3, 4 and 5; other modes see even areas.
    // The decode is only used at cycle start, so the live register is the right source.
    assign even_map = bus_control_r[EBC_BIT_AREA_DIVISION]
        || !(op_mode_i == EBC_MODE_3 || op_mode_i == EBC_MODE_4
        || op_mode_i == EBC_MODE_5); // R6

    ebc_area_decode u_dec (
        .addr_i(cyc_addr_i),
        .even_map_i(even_map),
        .area_o(dec_area),
        .external_o(dec_ext)
    );

    always_comb begin
        bus_control_nxt = bus_control_r;
        chip_select_control_nxt = chip_select_control_r;
        address_method_control_nxt = address_method_control_r;
        dat_nxt = dat_r;
        ack_nxt = 1'b0;
        err_nxt = 1'b0;
        if (req && !hit) begin
            err_nxt = 1'b1;
        end else if (req) begin
            ack_nxt = 1'b1;
            if (we_i && sel_i[0]) begin
                if (ofs_is(adr_i, EBC_OFS_BUS_CONTROL)) begin
                    // Bits five to three are stored as written; software keeps them zero.
                    bus_control_nxt = (dat_i[7:0] & EBC_BUS_CONTROL_WMASK)
                        | EBC_BUS_CONTROL_FIXED1; // R5 R4
                end
                if (ofs_is(adr_i, EBC_OFS_CHIP_SELECT_CONTROL) && !single_chip_i) begin // R11
                    chip_select_control_nxt = (dat_i[7:0] & EBC_CHIP_SELECT_CONTROL_WMASK)
                        | ~EBC_CHIP_SELECT_CONTROL_WMASK; // R5
                end
                if (ofs_is(adr_i, EBC_OFS_ADDRESS_METHOD_CONTROL)) begin
                    address_method_control_nxt = (dat_i[7:0] & EBC_ADDRESS_METHOD_CONTROL_WMASK)
                        | ~EBC_ADDRESS_METHOD_CONTROL_WMASK; // R5
                end
            end
            dat_nxt = 32'h0000_0000;
            if (ofs_is(adr_i, EBC_OFS_BUS_CONTROL)) begin
                dat_nxt[7:0] = bus_control_r;
            end else if (ofs_is(adr_i, EBC_OFS_CHIP_SELECT_CONTROL)) begin
                dat_nxt[7:0] = chip_select_control_r;
            end else begin
                dat_nxt[7:0] = address_method_control_r;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || hw_standby_i) begin
            bus_control_r <= EBC_BUS_CONTROL_RST; // R1
            chip_select_control_r <= EBC_CHIP_SELECT_CONTROL_RST; // R9
            address_method_control_r <= EBC_ADDRESS_METHOD_CONTROL_RST; // R12
            dat_r <= 32'h0000_0000;
            ack_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            bus_control_r <= bus_control_nxt;
            chip_select_control_r <= chip_select_control_nxt;
            address_method_control_r <= address_method_control_nxt;
            dat_r <= dat_nxt;
            ack_r <= ack_nxt;
            err_r <= err_nxt;
        end
    end

    assign dat_o = dat_r;
    assign ack_o = ack_r;
    assign err_o = err_r;

    always_comb begin
        state_nxt = state_r;
        bc_act_nxt = bc_act_r;
        last_read_nxt = last_read_r;
        last_area_nxt = last_area_r;
        cur_area_nxt = cur_area_r;
        addr_nxt = addr_r;
        idle_nxt = 1'b0;
        upd_nxt = 1'b0;
        if (state_r != EBC_ST_CYCLE) begin
            bc_act_nxt = bus_control_r; // R16
        end
        unique case (state_r)
            EBC_ST_IDLE, EBC_ST_GAP: begin
                if (cyc_start_i) begin
                    state_nxt = EBC_ST_CYCLE;
                    if (cyc_external_i && last_read_r) begin
                        if (!cyc_write_i && bus_control_r[EBC_BIT_CROSS_AREA_IDLE]
                            && dec_area != last_area_r) begin
                            idle_nxt = 1'b1; // R2
                        end
                        if (cyc_write_i && bus_control_r[EBC_BIT_READ_WRITE_IDLE]) begin
                            idle_nxt = 1'b1; // R3
                        end
                    end
                    // Mode 1 updates on every cycle, mode 2 only on external ones.
                    if (address_method_control_r[EBC_BIT_ADDRESS_METHOD] || cyc_external_i) begin
                        addr_nxt = cyc_addr_i; // R13 R14
                        upd_nxt = 1'b1; // R14
                    end
                    cur_area_nxt = dec_area;
                    last_read_nxt = cyc_external_i && !cyc_write_i;
                    last_area_nxt = dec_area;
                end
            end
            EBC_ST_CYCLE: begin
                if (cyc_end_i) begin
                    state_nxt = EBC_ST_GAP;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= EBC_ST_IDLE;
            bc_act_r <= EBC_BUS_CONTROL_RST;
            last_read_r <= 1'b0;
            last_area_r <= 3'h0;
            cur_area_r <= 3'h0;
            addr_r <= 24'h000000;
            idle_r <= 1'b0;
            upd_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            bc_act_r <= bc_act_nxt;
            last_read_r <= last_read_nxt;
            last_area_r <= last_area_nxt;
            cur_area_r <= cur_area_nxt;
            addr_r <= addr_nxt;
            idle_r <= idle_nxt;
            upd_r <= upd_nxt;
        end
    end

    assign insert_idle_o = idle_r;
    assign addr_update_o = upd_r;
    assign addr_o = addr_r;
    assign area_o = cur_area_r;
    assign wait_request_o = bc_act_r[EBC_BIT_WAIT_PIN] && !wait_pin_n_i; // R8
    assign wait_pin_is_port_o = !bus_control_r[EBC_BIT_WAIT_PIN]; // R8

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_sel
            // Select is low only during an external cycle to its own area.
            assign area_select_n_o[g] = !((state_r == EBC_ST_CYCLE) && !single_chip_i
                && cyc_external_i && cur_area_r == 3'(g)); // R15
        end
        for (g = 4; g < 8; g++) begin : g_oe
            assign upper_select_oe_o[g] = chip_select_control_r[g]; // R10
        end
    endgenerate
endmodule // ebc_regs

// >>> common/ebc_pkg.sv
// Purpose: Constants for the external bus control register bank.
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses.
// Notes: Register offsets are this block's own choice; the rules follow.
// Contract
// (R1) Bus control loads C6 at reset and hardware standby, keeps through software standby.
// (R2) Cross-area idle bit set inserts idle between reads to different areas.
// (R3) Read-write idle bit set inserts idle between read and following write.
// (R4) Software writes only zeros to bus control bits five to three.
// (R5) Reserved bits ignore writes and always read as one.
// (R6) Area division select acts only in modes 3, 4 and 5.
// (R7) Division select one gives eight 2 MB areas, zero gives the uneven map.
// (R8) Wait pin enable accepts external wait; zero frees pin as port.
// (R9) Chip-select control loads 0F at reset and hardware standby, keeps otherwise.
// (R10) Upper select enable forces pin to act as that area's select output.
// (R11) Chip-select control ignores writes in single-chip mode.
// (R12) Address method control loads FF at reset and hardware standby.
// (R13) Address method bit zero selects update mode 2, one mode 1.
// (R14) Mode 2 updates address only on external accesses; mode 1 every cycle.
// (R15) Area select low while its area is accessed in expanded mode.
// (R16) Register writes govern only bus cycles that begin after the write.
package ebc_pkg;
    localparam logic [3:0] EBC_OFS_BUS_CONTROL = 4'h0;
    localparam logic [3:0] EBC_OFS_CHIP_SELECT_CONTROL = 4'h4;
    localparam logic [3:0] EBC_OFS_ADDRESS_METHOD_CONTROL = 4'h8;
    localparam logic [7:0] EBC_BUS_CONTROL_RST = 8'hC6;
    localparam logic [7:0] EBC_CHIP_SELECT_CONTROL_RST = 8'h0F;
    localparam logic [7:0] EBC_ADDRESS_METHOD_CONTROL_RST = 8'hFF;
    localparam logic [7:0] EBC_BUS_CONTROL_FIXED1 = 8'h04;
    localparam logic [7:0] EBC_BUS_CONTROL_WMASK = 8'hFB;
    localparam logic [7:0] EBC_CHIP_SELECT_CONTROL_WMASK = 8'hF0;
    localparam logic [7:0] EBC_ADDRESS_METHOD_CONTROL_WMASK = 8'h01;
    localparam int EBC_BIT_CROSS_AREA_IDLE = 7;
    localparam int EBC_BIT_READ_WRITE_IDLE = 6;
    localparam int EBC_BIT_AREA_DIVISION = 1;
    localparam int EBC_BIT_WAIT_PIN = 0;
    localparam int EBC_BIT_ADDRESS_METHOD = 0;
    localparam int EBC_BIT_UPPER_SELECT_LO = 4;
    // Uneven map area start addresses for areas 1..7 (16-Mbyte space).
    localparam logic [23:0] EBC_A1_BASE = 24'h200000;
    localparam logic [23:0] EBC_A2_BASE = 24'h400000;
    localparam logic [23:0] EBC_A3_BASE = 24'hC00000;
    localparam logic [23:0] EBC_A4_BASE = 24'hE00000;
    localparam logic [23:0] EBC_A5_BASE = 24'hFEE000;
    localparam logic [23:0] EBC_A6_BASE = 24'hFEF000;
    localparam logic [23:0] EBC_A7_BASE = 24'hFFFFEA;
    localparam logic [23:0] EBC_A7_END = 24'hFFFFFF;
    localparam logic [2:0] EBC_MODE_3 = 3'h3;
    localparam logic [2:0] EBC_MODE_4 = 3'h4;
    localparam logic [2:0] EBC_MODE_5 = 3'h5;
    typedef enum logic [1:0] {
        EBC_ST_IDLE,
        EBC_ST_GAP,
        EBC_ST_CYCLE
    } ebc_state_t;
endpackage

// >>> rtl/ebc_area_decode.sv
// Purpose: Decodes a 24-bit address to one of eight areas.
// Assumes: 16-Mbyte address map.
// Notes: Combinational only.
module ebc_area_decode
    import ebc_pkg::*;
(
    // Address and map selection
    input wire logic [23:0] addr_i,
    input wire logic even_map_i,
    // Decoded area
    output logic [2:0] area_o,
    output logic external_o
);
    always_comb begin
        external_o = 1'b1;
        if (even_map_i) begin
            area_o = addr_i[23:21]; // R7
        end else begin
            area_o = 3'h0; // R7
            if (addr_i >= EBC_A7_BASE) begin
                area_o = 3'h7;
            end else if (addr_i >= EBC_A6_BASE) begin
                area_o = 3'h6;
            end else if (addr_i >= EBC_A5_BASE) begin
                area_o = 3'h5;
            end else if (addr_i >= EBC_A4_BASE) begin
                area_o = 3'h4;
            end else if (addr_i >= EBC_A3_BASE) begin
                area_o = 3'h3;
            end else if (addr_i >= EBC_A2_BASE) begin
                area_o = 3'h2;
            end else if (addr_i >= EBC_A1_BASE) begin
                area_o = 3'h1;
            end
        end
    end
endmodule // ebc_area_decode

// >>> testbench/ebc_checker.sv
// Purpose: Port assertions for the bus control register bank.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Bound to every ebc_regs instance.
module ebc_checker (
    // Clock, reset and register bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic err_o,
    // Bus cycle side
    input wire logic cyc_start_i,
    input wire logic cyc_external_i,
    input wire logic wait_pin_n_i,
    input wire logic insert_idle_o,
    input wire logic addr_update_o,
    input wire logic wait_request_o,
    input wire logic [7:0] area_select_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ANSWER_NEXT: assert property (cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o)
        else $error("register access not answered one cycle later");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
        else $error("acknowledge held longer than one cycle");
    AST_ACK_ERR: assert property (err_o |-> !ack_o)
        else $error("error and acknowledge together");
    AST_READ_UPPER: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("read data above bit 7 not zero");
    AST_IDLE_CAUSE: assert property (insert_idle_o |-> $past(cyc_start_i))
        else $error("idle pulse without a cycle start");
    AST_EXT_UPDATE: assert property (cyc_start_i && cyc_external_i |=> addr_update_o)
        else $error("external cycle without address update");
    AST_WAIT_PIN: assert property (wait_request_o |-> !wait_pin_n_i)
        else $error("wait request while wait pin is high");
    AST_SEL_INTERNAL: assert property (!cyc_external_i |-> area_select_n_o == 8'hFF)
        else $error("area select low on an internal access");
    cover property (insert_idle_o);
    cover property (err_o);
    cover property (wait_request_o);
endmodule // ebc_checker

bind ebc_regs ebc_checker i_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .dat_o, .ack_o, .err_o,
    .cyc_start_i, .cyc_external_i, .wait_pin_n_i, .insert_idle_o, .addr_update_o,
    .wait_request_o, .area_select_n_o);

// >>> testbench/ebc_seq_model.sv
// Purpose: Bus sequencer stand-in that issues bus cycles to the register bank.
// Assumes: One access state per bus cycle.
// Notes: Sampled controls are kept for the bench to compare.
module ebc_seq_model (
    // Clock
    input wire logic clk_i,
    // Cycle request and wait pin
    output logic start_o,
    output logic end_o,
    output logic write_o,
    output logic ext_o,
    output logic [23:0] addr_o,
    output logic wait_n_o,
    // Controls from the bank
    input wire logic idle_i,
    input wire logic upd_i,
    input wire logic wreq_i,
    input wire logic [2:0] area_i,
    input wire logic [7:0] sel_n_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic idle, upd, wreq;
    logic [2:0] area;
    logic [7:0] sel_n;
    initial begin
        {start_o, end_o, write_o, ext_o, wait_n_o} = 5'h01;
        addr_o = 24'h0;
    end
    task automatic run(input logic w, input logic e, input logic [23:0] a, input logic wt);
        @(posedge clk_i);
        {start_o, write_o, ext_o, addr_o, wait_n_o} <= {1'h1, w, e, a, !wt};
        @(posedge clk_i);
        {start_o, end_o} <= 2'h1;
        @(negedge clk_i);
        {idle, upd, wreq, area, sel_n} = {idle_i, upd_i, wreq_i, area_i, sel_n_i};
        @(posedge clk_i);
        // A released address bus must not keep showing the last value.
        {end_o, ext_o, addr_o, wait_n_o} <= {2'h0, ~a, 1'h1};
    endtask
endmodule // ebc_seq_model

// >>> testbench/tb_top.sv
// Purpose: Self-checking bench for the bus control register bank.
// Assumes: The register bus answers within a few cycles.
// Notes: Standby is applied only while no access is in flight.
module tb_top;
    import ebc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [23:0] BASES [7] = '{EBC_A1_BASE, EBC_A2_BASE, EBC_A3_BASE,
        EBC_A4_BASE, EBC_A5_BASE, EBC_A6_BASE, EBC_A7_BASE};
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic hw_standby_i = 1'h0;
    logic single_chip_i = 1'h0;
    logic cyc_i = 1'h0;
    logic stb_i = 1'h0;
    logic we_i = 1'h0;
    logic [2:0] op_mode_i = 3'h3;
    logic [3:0] adr_i = 4'h0;
    logic [3:0] sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o, rd;
    logic ack_o, err_o, cyc_start_i, cyc_end_i, cyc_write_i, cyc_external_i, wait_pin_n_i;
    logic insert_idle_o, addr_update_o, wait_request_o, wait_pin_is_port_o, got_err;
    logic [23:0] cyc_addr_i, addr_o;
    logic [7:0] area_select_n_o;
    logic [7:4] upper_select_oe_o;
    logic [2:0] area_o;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    always #50 clk_i = ~clk_i;
    ebc_regs i_dut (.clk_i, .rst_i, .hw_standby_i, .op_mode_i, .single_chip_i, .cyc_i, .stb_i,
        .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .err_o, .cyc_start_i, .cyc_end_i,
        .cyc_write_i, .cyc_external_i, .cyc_addr_i, .wait_pin_n_i, .insert_idle_o,
        .addr_update_o, .addr_o, .wait_request_o, .wait_pin_is_port_o, .area_select_n_o,
        .upper_select_oe_o, .area_o);
    ebc_seq_model i_seq (.clk_i, .start_o(cyc_start_i), .end_o(cyc_end_i),
        .write_o(cyc_write_i), .ext_o(cyc_external_i), .addr_o(cyc_addr_i),
        .wait_n_o(wait_pin_n_i), .idle_i(insert_idle_o), .upd_i(addr_update_o),
        .wreq_i(wait_request_o), .area_i(area_o), .sel_n_i(area_select_n_o));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // The request stays put until the edge that samples an answer.
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, 24'h0, d};
        do @(posedge clk_i); while (!(ack_o || err_o));
        {rd, got_err} = {dat_o, err_o};
        {cyc_i, stb_i, we_i} <= 3'h0;
    endtask
    task automatic rc(input string what, input logic [3:0] a, input logic [7:0] exp);
        wb(1'h0, a, 8'h0);
        chk(what, {24'h0, exp}, rd);
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        rc("bus_control", EBC_OFS_BUS_CONTROL, 8'hC6);
        rc("chip_select_control", EBC_OFS_CHIP_SELECT_CONTROL, 8'h0F);
        rc("address_method_control", EBC_OFS_ADDRESS_METHOD_CONTROL, 8'hFF);
        i_seq.run(1'h0, 1'h1, EBC_A1_BASE, 1'h1);
        chk("wait_request_o", 32'h0, 32'(i_seq.wreq));
        i_seq.run(1'h0, 1'h1, 24'h000010, 1'h0);
        chk("idle other area", 32'h1, 32'(i_seq.idle));
        i_seq.run(1'h0, 1'h1, 24'h000020, 1'h0);
        chk("idle same area", 32'h0, 32'(i_seq.idle));
        i_seq.run(1'h1, 1'h1, 24'h000030, 1'h0);
        chk("idle read write", 32'h1, 32'(i_seq.idle));
        wb(1'h1, EBC_OFS_BUS_CONTROL, 8'h03);
        rc("bus_control", EBC_OFS_BUS_CONTROL, 8'h07);
        chk("wait_pin_is_port_o", 32'h0, 32'(wait_pin_is_port_o));
        i_seq.run(1'h0, 1'h1, EBC_A1_BASE, 1'h1);
        chk("wait_request_o", 32'h1, 32'(i_seq.wreq));
        i_seq.run(1'h0, 1'h1, 24'h000010, 1'h0);
        chk("idle off", 32'h0, 32'(i_seq.idle));
        i_seq.run(1'h1, 1'h1, 24'h000020, 1'h0);
        chk("idle off", 32'h0, 32'(i_seq.idle));
        wb(1'h1, EBC_OFS_BUS_CONTROL, 8'h00);
        for (int i = 0; i < 7; i++) begin
            i_seq.run(1'h0, 1'h1, BASES[i], 1'h0);
            chk("area_o uneven", 32'(i + 1), 32'(i_seq.area));
            chk("area_select_n_o", 32'(8'hFF ^ (8'h01 << (i + 1))), 32'(i_seq.sel_n));
        end
        for (int m = 1; m <= 7; m++) begin
            op_mode_i <= 3'(m);
            i_seq.run(1'h0, 1'h1, 24'h600000, 1'h0);
            chk("area_o mode", (m >= 3 && m <= 5) ? 32'h2 : 32'h3, 32'(i_seq.area));
        end
        wb(1'h1, EBC_OFS_CHIP_SELECT_CONTROL, 8'hA0);
        rc("chip_select_control", EBC_OFS_CHIP_SELECT_CONTROL, 8'hAF);
        chk("upper_select_oe_o", 32'hA, 32'(upper_select_oe_o));
        single_chip_i <= 1'h1;
        wb(1'h1, EBC_OFS_CHIP_SELECT_CONTROL, 8'h50);
        rc("chip_select_control", EBC_OFS_CHIP_SELECT_CONTROL, 8'hAF);
        single_chip_i <= 1'h0;
        for (int k = 0; k < 4; k++) begin
            wb(1'h1, EBC_OFS_ADDRESS_METHOD_CONTROL, {7'h0, k[1]});
            rc("address_method_control", EBC_OFS_ADDRESS_METHOD_CONTROL, {7'h7F, k[1]});
            i_seq.run(1'h0, k[0], 24'h000040, 1'h0);
            chk("addr_update_o", 32'(k[0] | k[1]), 32'(i_seq.upd));
            chk("addr_o", (k == 0) ? 32'h600000 : 32'h000040, 32'(addr_o));
            chk("area_select_n_o", k[0] ? 32'hFE : 32'hFF, 32'(i_seq.sel_n));
        end
        wb(1'h1, 4'hC, 8'hFF);
        chk("err_o", 32'h1, 32'(got_err));
        @(posedge clk_i);
        hw_standby_i <= 1'h1;
        @(posedge clk_i);
        hw_standby_i <= 1'h0;
        rc("bus_control", EBC_OFS_BUS_CONTROL, 8'hC6);
        rc("chip_select_control", EBC_OFS_CHIP_SELECT_CONTROL, 8'h0F);
        rc("address_method_control", EBC_OFS_ADDRESS_METHOD_CONTROL, 8'hFF);
        chk("wait_pin_is_port_o", 32'h1, 32'(wait_pin_is_port_o));
        // A write that lands as a cycle starts must not change that cycle's wait enable.
        fork
            i_seq.run(1'h0, 1'h1, EBC_A1_BASE, 1'h1);
            wb(1'h1, EBC_OFS_BUS_CONTROL, 8'h03);
        join
        chk("wait latched at start", 32'h0, 32'(i_seq.wreq));
        i_seq.run(1'h0, 1'h1, EBC_A1_BASE, 1'h1);
        chk("wait_request_o", 32'h1, 32'(i_seq.wreq));
        stop_test();
    end
endmodule // tb_top
